// *** src/diag_result_pkg.sv ***
// Package for the cable diagnostic result register bank.
// Assumes an AHB-Lite slave with 32-bit data and one register per aligned word.
package diag_result_pkg;

    // Printed offsets are register indices; byte address is four times the index
    localparam logic [11:0] IDX_AMP2     = 12'h186;
    localparam logic [11:0] IDX_AMP3     = 12'h187;
    localparam logic [11:0] IDX_AMP4     = 12'h188;
    localparam logic [11:0] IDX_AMP5     = 12'h189;
    localparam logic [11:0] IDX_GENERAL  = 12'h18A;
    localparam logic [11:0] IDX_IRQ_STAT = 12'h190;
    localparam logic [11:0] IDX_IRQ_MASK = 12'h191;
    localparam logic [11:0] IDX_DONE     = 12'h192;

    localparam int AMP_HI_LSB   = 8;
    localparam int AMP_LO_LSB   = 0;
    localparam int POL_TX_LSB   = 11;
    localparam int POL_RX_LSB   = 6;
    localparam int CROSS_TX_BIT = 5;
    localparam int CROSS_RX_BIT = 4;
    localparam int OVER_TX_BIT  = 3;
    localparam int OVER_RX_BIT  = 2;

    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [1:0]  IRQ_RESET    = 2'h0;
    localparam int          IRQ_DONE_BIT = 0;
    localparam int          IRQ_FAULT_BIT = 1;

    typedef logic [6:0] amp_t;

    // One complete reflectometry result as delivered by the measurement engine
    typedef struct packed {
        amp_t [4:0] tx_amp;
        amp_t [4:0] rx_amp;
        logic [4:0] tx_pol;
        logic [4:0] rx_pol;
        logic       cross_tx;
        logic       cross_rx;
        logic       over_tx;
        logic       over_rx;
    } diag_result_s;

endpackage : diag_result_pkg

// *** src/diag_result_regs.sv ***
// Result register bank of the cable diagnostic engine, AHB-Lite slave.
// Assumes the engine presents a full result with a one-cycle result_valid
// pulse on mclk; diag_start restarts a run and clears the done indication.
// Summary of operation
// - Results valid only once done reads one
// - Reserved bits ignore writes, read zero
// - 0x186: tx peak four high, three low
// - 0x187: rx peak one high, tx five low
// - 0x188: rx peak three high, two low
// - 0x189: rx peak five high, four low
// - Amplitudes stored as measured reflection magnitude
// - General bits 15:11: tx polarities five..one
// - General bits 10:6: rx polarities five..one
// - Bit 5: cross reflection on tx pair
// - Bit 4: cross reflection on rx pair
// - Bit 3: over five tx reflections
// - Bit 2: over five rx reflections
`timescale 1ns/1ps
module diag_result_regs
    import diag_result_pkg::*;
(
    input  wire logic                         mclk,
    input  wire logic                         sys_rst,
    input  wire logic                         hsel,
    input  wire logic [31:0]                  haddr,
    input  wire logic [1:0]                   htrans,
    input  wire logic                         hwrite,
    input  wire logic [2:0]                   hsize,
    input  wire logic [31:0]                  hwdata,
    input  wire logic                         hready,
    output logic      [31:0]                  hrdata,
    output logic                              hreadyout,
    output logic                              hresp,
    input  wire logic                         diag_start,
    input  wire logic                         result_valid,
    input  wire diag_result_pkg::diag_result_s result_in,
    output logic                              diag_done,
    output logic                              irq
);
    import diag_result_pkg::*;

    diag_result_s res;
    logic [1:0]   irq_stat;
    logic [1:0]   irq_mask;
    logic         wr_pend;
    logic [11:0]  wr_idx;
    logic [15:0]  rd_word;
    logic [11:0]  a_idx;
    logic [1:0]   w1c;
    logic [1:0]   irq_set;

    assign a_idx = haddr[13:2];

    // Whole result captured in one edge so no mix of runs is visible
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            res <= '0;
        end else if (result_valid) begin
            res <= result_in;
        end
    end

    // Done follows the same edge that loads the result
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            diag_done <= 1'b0;
        end else if (result_valid) begin
            diag_done <= 1'b1;
        end else if (diag_start) begin
            diag_done <= 1'b0;
        end
    end

    // Read mux; amplitude and result registers are read-only
    always_comb begin
        rd_word = RESULT_RESET;
        unique case (a_idx)
            IDX_AMP2: begin
                rd_word[AMP_HI_LSB +: 7] = res.tx_amp[3];
                rd_word[AMP_LO_LSB +: 7] = res.tx_amp[2];
            end
            IDX_AMP3: begin
                rd_word[AMP_HI_LSB +: 7] = res.rx_amp[0];
                rd_word[AMP_LO_LSB +: 7] = res.tx_amp[4];
            end
            IDX_AMP4: begin
                rd_word[AMP_HI_LSB +: 7] = res.rx_amp[2];
                rd_word[AMP_LO_LSB +: 7] = res.rx_amp[1];
            end
            IDX_AMP5: begin
                rd_word[AMP_HI_LSB +: 7] = res.rx_amp[4];
                rd_word[AMP_LO_LSB +: 7] = res.rx_amp[3];
            end
            IDX_GENERAL: begin
                rd_word[POL_TX_LSB +: 5] = res.tx_pol;
                rd_word[POL_RX_LSB +: 5] = res.rx_pol;
                rd_word[CROSS_TX_BIT]    = res.cross_tx;
                rd_word[CROSS_RX_BIT]    = res.cross_rx;
                rd_word[OVER_TX_BIT]     = res.over_tx;
                rd_word[OVER_RX_BIT]     = res.over_rx;
            end
            IDX_IRQ_STAT: rd_word[1:0] = irq_stat;
            IDX_IRQ_MASK: rd_word[1:0] = irq_mask;
            IDX_DONE:     rd_word[0]   = diag_done;
            default:      rd_word = RESULT_RESET;
        endcase
    end

    // Zero-wait slave: read data registered at the address phase edge
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (hsel && hready && htrans[1] && !hwrite) begin
                hrdata <= {16'h0000, rd_word};
            end
        end
    end

    // Writes land on the following edge when hwdata is valid
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wr_pend <= 1'b0;
            wr_idx  <= 12'h000;
        end else begin
            wr_pend <= hsel && hready && htrans[1] && hwrite;
            wr_idx  <= a_idx;
        end
    end

    // Only the mask and the status are writable; result writes are dropped
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            irq_mask <= IRQ_RESET;
        end else if (wr_pend && wr_idx == IDX_IRQ_MASK) begin
            irq_mask <= hwdata[1:0];
        end
    end

    assign w1c     = (wr_pend && wr_idx == IDX_IRQ_STAT) ? hwdata[1:0] : 2'h0;
    assign irq_set = {result_valid && (result_in.cross_tx || result_in.cross_rx
                                       || result_in.over_tx || result_in.over_rx),
                      result_valid};

    // Set wins over a simultaneous write-one clear
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            irq_stat <= IRQ_RESET;
        end else begin
            irq_stat <= (irq_stat & ~w1c) | irq_set;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((irq_stat & ~w1c) | irq_set) & irq_mask);
        end
    end

endmodule : diag_result_regs

// *** tb/diag_result_regs_sva.sv ***
// Checker for the result bank: bus answers, reserved bits, done flag.
// Assumes one slave whose hreadyout is fed back as hready.
`timescale 1ns/1ps
module diag_result_regs_sva
    import diag_result_pkg::*;
(
    input wire logic                          mclk,
    input wire logic                          sys_rst,
    input wire logic                          hsel,
    input wire logic [31:0]                   haddr,
    input wire logic [1:0]                    htrans,
    input wire logic                          hwrite,
    input wire logic                          hready,
    input wire logic [31:0]                   hrdata,
    input wire logic                          hreadyout,
    input wire logic                          hresp,
    input wire logic                          diag_start,
    input wire logic                          result_valid,
    input wire diag_result_pkg::diag_result_s result_in,
    input wire logic                          diag_done
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence rd(a);
        hsel && hready && htrans[1] && !hwrite && haddr == a;
    endsequence
    sequence cap;
        result_valid && !diag_start;
    endsequence
    AST_DONE_SET: assert property (cap |=> diag_done) else $error("done late");
    AST_DONE_CLR: assert property (diag_start && !result_valid |=> !diag_done)
        else $error("done kept");
    AST_READY: assert property (hreadyout && !hresp) else $error("wait or error");
    AST_TOP_ZERO: assert property (hrdata[31:16] == 16'h0000) else $error("top set");
    AST_AMP_RSV: assert property (rd(32'h618) or rd(32'h624) |=> !hrdata[15] && !hrdata[7])
        else $error("amp reserved set");
    AST_GEN_RSV: assert property (rd(32'h628) |=> hrdata[1:0] == 2'h0)
        else $error("general reserved set");
    AST_AMP2: assert property (cap ##1 rd(32'h618) |=>
        hrdata[14:8] == $past(result_in.tx_amp[3], 2)) else $error("peak four wrong");
    AST_HOLD: assert property (!(hsel && hready && htrans[1]) |=> $stable(hrdata))
        else $error("data moved");
endmodule : diag_result_regs_sva
bind diag_result_regs diag_result_regs_sva u_sva (.mclk, .sys_rst, .hsel, .haddr, .htrans,
    .hwrite, .hready, .hrdata, .hreadyout, .hresp, .diag_start, .result_valid, .result_in,
    .diag_done);

// *** tb/diag_result_regs_bench.sv ***
// Bench for the result bank: drives bus and engine ports itself.
// Assumes zero-wait reads; hready is looped back from hreadyout.
`timescale 1ns/1ps
module diag_result_regs_bench;
    import diag_result_pkg::*;
    logic         mclk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic         diag_start = 1'b0, result_valid = 1'b0, hreadyout, hresp, diag_done, irq;
    logic [31:0]  haddr = '0, hwdata = '0, hrdata, d;
    logic [1:0]   htrans = 2'h0;
    diag_result_s result_in = '0, r = '0;
    int           errors = 0, cmp_count = 0;
    always #50 mclk = ~mclk;
    diag_result_regs u_dut (.mclk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .diag_start,
        .result_valid, .result_in, .diag_done, .irq);
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [11:0] i, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {18'h0, i, 2'h0};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask : xfer
    function automatic logic [31:0] expw(input logic [11:0] i);
        case (i)
            IDX_AMP2: return {17'h0, r.tx_amp[3], 1'b0, r.tx_amp[2]};
            IDX_AMP3: return {17'h0, r.rx_amp[0], 1'b0, r.tx_amp[4]};
            IDX_AMP4: return {17'h0, r.rx_amp[2], 1'b0, r.rx_amp[1]};
            IDX_AMP5: return {17'h0, r.rx_amp[4], 1'b0, r.rx_amp[3]};
            IDX_GENERAL: return {16'h0, r.tx_pol, r.rx_pol, r.cross_tx, r.cross_rx,
                r.over_tx, r.over_rx, 2'h0};
            default: return '0;
        endcase
    endfunction : expw
    task automatic t_results(input diag_result_s v);
        diag_start <= 1'b1;
        @(posedge mclk);
        diag_start <= 1'b0;
        xfer(1'b1, IDX_GENERAL, 32'hFFFFFFFF);
        chk({31'h0, diag_done}, 32'h0);
        xfer(1'b0, IDX_GENERAL, '0);
        chk(d, expw(IDX_GENERAL));
        result_in <= v;
        result_valid <= 1'b1;
        @(posedge mclk);
        result_valid <= 1'b0;
        r = v;
        for (int i = 0; i < 5; i++) begin
            xfer(1'b0, IDX_AMP2 + 12'(i), '0);
            chk(d, expw(IDX_AMP2 + 12'(i)));
        end
        chk({31'h0, diag_done}, 32'h1);
        $display("results test done");
    endtask : t_results
    task automatic t_irq;
        xfer(1'b0, IDX_IRQ_STAT, '0);
        chk(d, 32'h3);
        chk({31'h0, irq}, 32'h0);
        xfer(1'b1, IDX_IRQ_MASK, 32'h2);
        repeat (3) @(posedge mclk);
        chk({31'h0, irq}, 32'h1);
        xfer(1'b1, IDX_IRQ_STAT, 32'h2);
        repeat (3) @(posedge mclk);
        chk({31'h0, irq}, 32'h0);
        xfer(1'b0, 12'h1FF, '0);
        chk(d, 32'h0);
        $display("irq test done");
    endtask : t_irq
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            xfer(1'b0, IDX_AMP2 + 12'(i), '0);
            chk(d, 32'h0);
        end
        t_results('1);
        t_irq;
        t_results(diag_result_s'(84'hA5C39E17F0B46D28E1B7C));
        end_of_test;
    end
    // Run needs about 63 cycles; 500 leaves room without hiding a hang
    initial begin
        #50000;
        errors++;
        end_of_test;
    end
endmodule : diag_result_regs_bench
